// ==== ipc_pkg.sv ====
package ipc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte-wide registers, one per address)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_MAIN   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO    = 4'h1;
  localparam logic [3:0] ADDR_CTRL_THREE  = 4'h2;
  localparam logic [3:0] ADDR_PERIPH_PRI6 = 4'h3;
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h4;
  localparam logic [3:0] ADDR_TMR_LO      = 4'h5;
  localparam logic [3:0] ADDR_TMR_HI      = 4'h6;
  localparam logic [3:0] ADDR_TMR_CFG     = 4'h7;
  localparam logic [3:0] ADDR_PERIPH_FLAG = 4'h8;
  localparam logic [3:0] ADDR_PERIPH_EN   = 4'h9;
  localparam logic [3:0] ADDR_VECTOR_STAT = 4'hA;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAIN_GIE_BIT  = 7;
  localparam int MAIN_GIEL_BIT = 6;
  localparam int MAIN_T0IE_BIT = 5;
  localparam int MAIN_I0IE_BIT = 4;
  localparam int MAIN_PORT_CHANGE_ENABLE_BIT = 3;
  localparam int MAIN_T0IF_BIT = 2;
  localparam int MAIN_I0IF_BIT = 1;
  localparam int MAIN_PORT_CHANGE_FLAG_BIT = 0;
  localparam int TWO_EDGE0_BIT = 6;
  localparam int TWO_T0IP_BIT  = 2;
  localparam int TWO_I3IP_BIT  = 1;
  localparam int TWO_PORT_CHANGE_PRIORITY_BIT  = 0;
  localparam int THR_I2IP_BIT  = 7;
  localparam int THR_I1IP_BIT  = 6;
  localparam int THR_IE1_BIT   = 3;
  localparam int THR_IF1_BIT   = 0;
  localparam int RC_PRIORITY_LEVELS_ENABLE_BIT   = 7;
  localparam int RC_CM_BIT     = 5;
  localparam int CFG_16BIT_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_RST       = 8'h00;
  localparam logic [7:0] TWO_RST        = 8'hFF;
  localparam logic [7:0] THREE_RST      = 8'hC0;
  localparam logic [7:0] PRI6_RST       = 8'h17;
  localparam logic [7:0] PRI6_MASK      = 8'h17;
  localparam logic [7:0] RESET_CAUSE_RST = 8'h7C;
  localparam logic [7:0] RC_WR_MASK     = 8'hF3;
  localparam logic [7:0] PERIPH_MASK    = 8'h17;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ipc_bus_req_t;

  typedef struct packed {
    logic [7:0] working;
    logic [7:0] status;
    logic [7:0] bank;
  } ipc_ctx_t;

  typedef enum logic [1:0] {
    IPC_RUN   = 2'b00,
    IPC_ENTRY = 2'b01,
    IPC_ISR   = 2'b11
  } ipc_state_t;

endpackage

// ==== ipc_irq_ctrl.sv ====
`timescale 1ns/1ns
module ipc_irq_ctrl #(
  parameter int PC_W = 21
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire ipc_pkg::ipc_bus_req_t bus_i,
  output logic [7:0]             rdata_o,
  input  wire logic [3:0]        ext_pin_i,
  input  wire logic [7:4]        port_b_pins_i,
  input  wire logic              tmr_tick_i,
  input  wire logic [2:0]        comparator_evt_i,
  input  wire logic              nvm_evt_i,
  input  wire logic              config_mismatch_i,
  input  wire logic              sleeping_i,
  input  wire logic              ack_i,
  input  wire logic              retfie_i,
  input  wire logic [PC_W-1:0]   pc_i,
  input  wire ipc_pkg::ipc_ctx_t ctx_i,
  output logic                   wake_o,
  output logic                   vector_req_o,
  output logic                   vector_high_o,
  output logic                   push_o,
  output logic [PC_W-1:0]        push_pc_o,
  output ipc_pkg::ipc_ctx_t      fast_ctx_o
);
  import ipc_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]      main_r, main_nxt;
  logic [7:0]      two_r, two_nxt;
  logic [7:0]      three_r, three_nxt;
  logic [7:0]      pri6_r, pri6_nxt;
  logic [7:0]      rcause_r, rcause_nxt;
  logic [7:0]      pflag_r, pflag_nxt;
  logic [7:0]      pen_r, pen_nxt;
  logic [15:0]     tmr_r, tmr_nxt;
  logic            tmr16_r, tmr16_nxt;
  logic [3:0]      pin_q_r, pin_q_nxt;
  logic [7:4]      pb_q_r, pb_q_nxt;
  logic [7:0]      rdata_r, rdata_nxt;

  // ----------------------------------------------------------------
  // vectoring state
  // ----------------------------------------------------------------
  ipc_state_t      st_r, st_nxt;
  logic            wake_r, wake_nxt;
  logic            vreq_r, vreq_nxt;
  logic            vhigh_r, vhigh_nxt;
  logic            push_r, push_nxt;
  logic [PC_W-1:0] ppc_r, ppc_nxt;
  ipc_ctx_t        fctx_r, fctx_nxt;

  function automatic logic wr_hit(input ipc_bus_req_t b, input logic [3:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  // one selects the rising edge, zero the falling one
  function automatic logic edge_hit(input logic pol, input logic cur, input logic prev);
    edge_hit = pol ? (cur && !prev) : (!cur && prev);
  endfunction

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic [3:0] pin_edge;
  logic       pb_change;
  logic       tmr_wrap;
  logic [3:0] pin_en;
  logic [3:0] pin_flag;
  logic [3:0] pin_pol;

  always_comb begin
    pin_pol  = {two_r[TWO_EDGE0_BIT-3], two_r[TWO_EDGE0_BIT-2],
                two_r[TWO_EDGE0_BIT-1], two_r[TWO_EDGE0_BIT]};
    for (int i = 0; i < 4; i++) begin
      pin_edge[i] = edge_hit(pin_pol[i], ext_pin_i[i], pin_q_r[i]);
    end
    pb_change = (port_b_pins_i != pb_q_r);
    tmr_wrap  = tmr_tick_i && (tmr16_r ? (tmr_r == 16'hFFFF)
                                       : (tmr_r[7:0] == 8'hFF));
    pin_en   = {three_r[THR_IE1_BIT+2:THR_IE1_BIT], main_r[MAIN_I0IE_BIT]};
    pin_flag = {three_r[THR_IF1_BIT+2:THR_IF1_BIT], main_r[MAIN_I0IF_BIT]};
  end

  // ----------------------------------------------------------------
  // register file: writes first, hardware sets win over them
  // ----------------------------------------------------------------
  always_comb begin
    main_nxt   = main_r;
    two_nxt    = two_r;
    three_nxt  = three_r;
    pri6_nxt   = pri6_r;
    rcause_nxt = rcause_r;
    pflag_nxt  = pflag_r;
    pen_nxt    = pen_r;
    if (wr_hit(bus_i, ADDR_CTRL_MAIN)) main_nxt = bus_i.wdata;
    if (wr_hit(bus_i, ADDR_CTRL_TWO)) two_nxt = bus_i.wdata;
    if (wr_hit(bus_i, ADDR_CTRL_THREE)) three_nxt = bus_i.wdata;
    if (wr_hit(bus_i, ADDR_PERIPH_PRI6)) pri6_nxt = bus_i.wdata & PRI6_MASK;
    if (wr_hit(bus_i, ADDR_PERIPH_FLAG)) pflag_nxt = bus_i.wdata & PERIPH_MASK;
    if (wr_hit(bus_i, ADDR_PERIPH_EN)) pen_nxt = bus_i.wdata & PERIPH_MASK;
    if (wr_hit(bus_i, ADDR_RESET_CAUSE)) begin
      // status bits owned by the reset unit are not writable here
      rcause_nxt = (bus_i.wdata & RC_WR_MASK) | (rcause_r & ~RC_WR_MASK);
    end
    // hardware sets, and the config-mismatch clear of the reset-cause bit
    if (tmr_wrap) main_nxt[MAIN_T0IF_BIT] = 1'b1;
    if (pb_change) main_nxt[MAIN_PORT_CHANGE_FLAG_BIT] = 1'b1;
    if (pin_edge[0]) main_nxt[MAIN_I0IF_BIT] = 1'b1;
    for (int i = 1; i < 4; i++) begin
      if (pin_edge[i]) three_nxt[THR_IF1_BIT+i-1] = 1'b1;
    end
    pflag_nxt = pflag_nxt | ({3'h0, nvm_evt_i, 1'b0, comparator_evt_i} & PERIPH_MASK);
    if (config_mismatch_i) rcause_nxt[RC_CM_BIT] = 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      main_r   <= MAIN_RST;
      two_r    <= TWO_RST;
      three_r  <= THREE_RST;
      pri6_r   <= PRI6_RST;
      rcause_r <= RESET_CAUSE_RST;
      pflag_r  <= 8'h00;
      pen_r    <= 8'h00;
    end else begin
      main_r   <= main_nxt;
      two_r    <= two_nxt;
      three_r  <= three_nxt;
      pri6_r   <= pri6_nxt;
      rcause_r <= rcause_nxt;
      pflag_r  <= pflag_nxt;
      pen_r    <= pen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // timer count: a software load of either byte overrides the tick for that byte in that cycle
  // ----------------------------------------------------------------
  always_comb begin
    tmr_nxt   = tmr_r;
    tmr16_nxt = tmr16_r;
    if (wr_hit(bus_i, ADDR_TMR_CFG)) tmr16_nxt = bus_i.wdata[CFG_16BIT_BIT];
    // 8-bit mode leaves the high byte alone
    if (tmr_tick_i) begin
      tmr_nxt = tmr16_r ? (tmr_r + 16'h0001) : {tmr_r[15:8], tmr_r[7:0] + 8'h01};
    end
    if (wr_hit(bus_i, ADDR_TMR_LO)) tmr_nxt[7:0] = bus_i.wdata;
    if (wr_hit(bus_i, ADDR_TMR_HI)) tmr_nxt[15:8] = bus_i.wdata;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tmr_r   <= 16'h0000;
      tmr16_r <= 1'b0;
    end else begin
      tmr_r   <= tmr_nxt;
      tmr16_r <= tmr16_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin history for edge and change detection
  // ----------------------------------------------------------------
  // history resets low: a pin already high at release reads as a rise
  always_comb begin
    pin_q_nxt = ext_pin_i;
    pb_q_nxt  = port_b_pins_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_q_r <= 4'h0;
      pb_q_r  <= 4'h0;
    end else begin
      pin_q_r <= pin_q_nxt;
      pb_q_r  <= pb_q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read port: data stand one cycle, zero otherwise
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_CTRL_MAIN:   rdata_nxt = main_r;
        ADDR_CTRL_TWO:    rdata_nxt = two_r;
        ADDR_CTRL_THREE:  rdata_nxt = three_r;
        ADDR_PERIPH_PRI6: rdata_nxt = pri6_r & PRI6_MASK;
        ADDR_RESET_CAUSE: rdata_nxt = rcause_r;
        ADDR_TMR_LO:      rdata_nxt = tmr_r[7:0];
        ADDR_TMR_HI:      rdata_nxt = tmr_r[15:8];
        ADDR_TMR_CFG:     rdata_nxt = {7'h00, tmr16_r};
        ADDR_PERIPH_FLAG: rdata_nxt = pflag_r;
        ADDR_PERIPH_EN:   rdata_nxt = pen_r;
        ADDR_VECTOR_STAT: rdata_nxt = {6'h00, st_r};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // request qualification and priority
  // ----------------------------------------------------------------
  logic [8:0] src_act;
  logic [8:0] src_pri;
  logic       priority_levels_enable;
  logic       any_hi;
  logic       any_lo;
  logic       any_en;
  logic       pend_hi;
  logic       pend_lo;

  always_comb begin
    priority_levels_enable = rcause_r[RC_PRIORITY_LEVELS_ENABLE_BIT];
    src_act[0] = pin_flag[0] && pin_en[0];
    src_act[3:1] = pin_flag[3:1] & pin_en[3:1];
    src_act[4] = main_r[MAIN_T0IF_BIT] && main_r[MAIN_T0IE_BIT];
    src_act[5] = main_r[MAIN_PORT_CHANGE_FLAG_BIT] && main_r[MAIN_PORT_CHANGE_ENABLE_BIT];
    src_act[8:6] = pflag_r[2:0] & pen_r[2:0];
    src_pri[0] = 1'b1;
    src_pri[1] = three_r[THR_I1IP_BIT];
    src_pri[2] = three_r[THR_I2IP_BIT];
    src_pri[3] = two_r[TWO_I3IP_BIT];
    src_pri[4] = two_r[TWO_T0IP_BIT];
    src_pri[5] = two_r[TWO_PORT_CHANGE_PRIORITY_BIT];
    src_pri[8:6] = pri6_r[2:0];
    any_hi = |(src_act & src_pri) || (pflag_r[4] && pen_r[4] && pri6_r[4]);
    any_lo = |(src_act & ~src_pri) || (pflag_r[4] && pen_r[4] && !pri6_r[4]);
    any_en = any_hi || any_lo;
    // single-level mode: bit 7 is the global enable, bit 6 the peripheral one
    if (priority_levels_enable) begin
      pend_hi = any_hi && main_r[MAIN_GIE_BIT];
      pend_lo = any_lo && main_r[MAIN_GIE_BIT] && main_r[MAIN_GIEL_BIT];
    end else begin
      pend_hi = main_r[MAIN_GIE_BIT] && (|src_act[5:0] ||
                (main_r[MAIN_GIEL_BIT] && (|src_act[8:6] || (pflag_r[4] && pen_r[4]))));
      pend_lo = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wake and vector sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    vreq_nxt  = 1'b0;
    vhigh_nxt = vhigh_r;
    push_nxt  = 1'b0;
    ppc_nxt   = ppc_r;
    fctx_nxt  = fctx_r;
    // wake needs only an enabled flag, not the global enable
    wake_nxt  = sleeping_i && (|(pin_flag & pin_en) || any_en);
    case (st_r)
      IPC_RUN: begin
        // a woken core with globals off just resumes; no vector
        if (pend_hi || pend_lo) begin
          st_nxt    = IPC_ENTRY;
          vreq_nxt  = 1'b1;
          vhigh_nxt = pend_hi || !priority_levels_enable;
        end
      end
      IPC_ENTRY: begin
        vreq_nxt = !ack_i;
        if (ack_i) begin
          st_nxt   = IPC_ISR;
          push_nxt = 1'b1;
          ppc_nxt  = pc_i;
          fctx_nxt = ctx_i;
        end
      end
      IPC_ISR: begin
        if (retfie_i) st_nxt = IPC_RUN;
      end
      default: st_nxt = IPC_RUN;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r    <= IPC_RUN;
      wake_r  <= 1'b0;
      vreq_r  <= 1'b0;
      vhigh_r <= 1'b0;
      push_r  <= 1'b0;
      ppc_r   <= '0;
      fctx_r  <= '0;
    end else begin
      st_r    <= st_nxt;
      wake_r  <= wake_nxt;
      vreq_r  <= vreq_nxt;
      vhigh_r <= vhigh_nxt;
      push_r  <= push_nxt;
      ppc_r   <= ppc_nxt;
      fctx_r  <= fctx_nxt;
    end
  end

  assign rdata_o       = rdata_r;
  assign wake_o        = wake_r;
  assign vector_req_o  = vreq_r;
  assign vector_high_o = vhigh_r;
  assign push_o        = push_r;
  assign push_pc_o     = ppc_r;
  assign fast_ctx_o    = fctx_r;

endmodule

// ==== ipc_irq_ctrl_checker.sv ====
`timescale 1ns/1ns
module ipc_irq_ctrl_checker #(
  parameter int PC_W = 21
) (
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire ipc_pkg::ipc_bus_req_t bus_i,
  input  wire logic [7:0]            rdata_o,
  input  wire logic                  sleeping_i,
  input  wire logic                  ack_i,
  input  wire logic [PC_W-1:0]       pc_i,
  input  wire ipc_pkg::ipc_ctx_t     ctx_i,
  input  wire logic                  wake_o,
  input  wire logic                  vector_req_o,
  input  wire logic                  vector_high_o,
  input  wire logic                  push_o,
  input  wire logic [PC_W-1:0]       push_pc_o,
  input  wire ipc_pkg::ipc_ctx_t     fast_ctx_o
);
  import ipc_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ------------------------------------------------------------
  // entry sequence
  // ------------------------------------------------------------
  push_after_ack_a: assert property (vector_req_o && ack_i |=> push_o && !vector_req_o)
    else $error("no push after ack");
  push_pc_a: assert property (push_o |-> push_pc_o == $past(pc_i))
    else $error("wrong pushed pc");
  fast_ctx_a: assert property (push_o |-> fast_ctx_o == $past(ctx_i))
    else $error("wrong fast context");
  push_single_a: assert property (push_o |=> !push_o)
    else $error("push longer than one cycle");
  push_cause_a: assert property (push_o |-> $past(vector_req_o) && $past(ack_i))
    else $error("push without accepted vector");
  req_hold_a: assert property (vector_req_o && !ack_i |=> vector_req_o)
    else $error("vector request dropped early");
  // ------------------------------------------------------------
  // registers and wake
  // ------------------------------------------------------------
  pri_unused_a: assert property (bus_i.rd && bus_i.addr == ADDR_PERIPH_PRI6 |=>
                                 (rdata_o & 8'hE8) == 8'h00)
    else $error("unused priority bits read nonzero");
  wake_awake_a: assert property (!sleeping_i |=> !wake_o)
    else $error("wake while not sleeping");
  cover property (push_o);
  cover property (wake_o);
  cover property (vector_req_o && !vector_high_o);
endmodule

// ==== ipc_core_model.sv ====
`timescale 1ns/1ns
module ipc_core_model #(
  parameter int PC_W = 21
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              slow_i,
  input  wire logic              vector_req_i,
  input  wire logic              isr_done_i,
  output logic                   ack_o,
  output logic                   retfie_o,
  output logic [PC_W-1:0]        pc_o,
  output ipc_pkg::ipc_ctx_t      ctx_o
);
  import ipc_pkg::*;
  logic [2:0] wait_r;
  // pc and context move every cycle so a late capture shows up
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ack_o    <= 1'b0;
      retfie_o <= 1'b0;
      wait_r   <= 3'h0;
      pc_o     <= '0;
    end else begin
      pc_o     <= pc_o + 1'b1;
      wait_r   <= (vector_req_i && !ack_o) ? wait_r + 3'h1 : 3'h0;
      ack_o    <= vector_req_i && !ack_o && (!slow_i || wait_r == 3'h4);
      retfie_o <= isr_done_i;
    end
  end
  assign ctx_o = '{working: pc_o[7:0], status: ~pc_o[7:0], bank: pc_o[15:8]};
endmodule

// ==== ipc_irq_ctrl_tb.sv ====
`timescale 1ns/1ns
module ipc_irq_ctrl_tb;
  import ipc_pkg::*;
  logic         mclk_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  ipc_bus_req_t bus = '0;
  logic [3:0]   pins = 4'h0;
  logic [7:4]   pb = 4'h0;
  logic [2:0]   cmp = 3'h0;
  logic         tick = 0, cm = 0, nvm = 0, slp = 0, slow = 0, done = 0, rd_d = 0, vq_d = 0;
  logic         ack, ret, wake, vreq, vhigh, push;
  logic [7:0]   rdata;
  logic [20:0]  pc, ppc;
  ipc_ctx_t     ctx, fctx;
  logic [7:0]   rd_q[$];
  logic         vh_q[$];
  int           err_count = 0, cmp_count = 0, seed;
  always #5 mclk_i = ~mclk_i;
  ipc_irq_ctrl ipc_irq_ctrl_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
    .rdata_o(rdata), .ext_pin_i(pins), .port_b_pins_i(pb), .tmr_tick_i(tick),
    .comparator_evt_i(cmp), .nvm_evt_i(nvm), .config_mismatch_i(cm), .sleeping_i(slp),
    .ack_i(ack), .retfie_i(ret), .pc_i(pc), .ctx_i(ctx), .wake_o(wake), .vector_req_o(vreq),
    .vector_high_o(vhigh), .push_o(push), .push_pc_o(ppc), .fast_ctx_o(fctx));
  ipc_core_model ipc_core_model_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
    .vector_req_i(vreq), .isr_done_i(done), .ack_o(ack), .retfie_o(ret), .pc_o(pc),
    .ctx_o(ctx));
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: %s got %h exp %h", $time, m, s, e);
    end
  endtask
  task automatic results();
    // a note never matched by a result is a miss as well
    if (rd_q.size() != 0 || vh_q.size() != 0) err_count++;
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // monitor: oldest note against each result
  // ------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rd_d) chk(rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx, "read data");
    if (vreq && !vq_d) begin
      chk(vhigh, (vh_q.size() > 0) ? vh_q.pop_front() : 1'bx, "vector level");
    end
    rd_d <= bus.rd;
    vq_d <= vreq;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge mclk_i);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    bus <= '0;
  endtask
  task automatic fire(input logic [2:0] c, input logic n, input logic m, input int t);
    @(posedge mclk_i);
    {cmp, nvm, cm} <= {c, n, m};
    tick <= (t > 0);
    @(posedge mclk_i);
    {cmp, nvm, cm} <= '0;
    repeat (t - 1) @(posedge mclk_i);
    tick <= 1'b0;
  endtask
  // the service step clears the source before returning
  task automatic take(input logic vh, input logic [3:0] a, input logic [7:0] d);
    int k;
    vh_q.push_back(vh);
    k = 0;
    while (push !== 1'b1 && k < 40) begin
      @(negedge mclk_i);
      k++;
    end
    chk(push, 1'b1, "vector entry");
    wr(a, d);
    @(posedge mclk_i);
    done <= 1'b1;
    @(posedge mclk_i);
    done <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  initial begin
    seed = $urandom(2586);
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_CTRL_MAIN, MAIN_RST);
    rd(ADDR_CTRL_TWO, TWO_RST);
    rd(ADDR_CTRL_THREE, THREE_RST);
    rd(ADDR_PERIPH_PRI6, PRI6_RST);
    rd(ADDR_RESET_CAUSE, RESET_CAUSE_RST);
    rd(4'hB, 8'h00);
    rd(ADDR_VECTOR_STAT, 8'h00);
    wr(ADDR_PERIPH_PRI6, 8'hFF);
    rd(ADDR_PERIPH_PRI6, 8'h17);
    wr(ADDR_PERIPH_PRI6, 8'hE8);
    rd(ADDR_PERIPH_PRI6, 8'h00);
    fire(3'h0, 1'b0, 1'b1, 0);
    rd(ADDR_RESET_CAUSE, 8'h5C);
    wr(ADDR_RESET_CAUSE, 8'h20);
    rd(ADDR_RESET_CAUSE, 8'h2C);
    // legacy mode: flag without enable, then wake without global enable
    pins[0] <= 1'b1;
    rd(ADDR_CTRL_MAIN, 8'h02);
    @(negedge mclk_i);
    chk(vreq, 1'b0, "vector while disabled");
    @(posedge mclk_i);
    slp <= 1'b1;
    wr(ADDR_CTRL_MAIN, 8'h10);
    pins[0] <= 1'b0;
    rd(ADDR_CTRL_MAIN, 8'h10);
    wr(ADDR_CTRL_TWO, 8'hBF);
    pins[0] <= 1'b1;
    rd(ADDR_CTRL_MAIN, 8'h10);
    pins[0] <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(wake, 1'b1, "wake");
    chk(vreq, 1'b0, "vector without global enable");
    @(posedge mclk_i);
    slp <= 1'b0;
    wr(ADDR_CTRL_MAIN, 8'h92);
    take(1'b1, ADDR_CTRL_MAIN, 8'h90);
    // priority mode, slow core
    slow <= 1'b1;
    wr(ADDR_RESET_CAUSE, 8'hA0);
    rd(ADDR_RESET_CAUSE, 8'hAC);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL_TWO, {5'b11111, p[0], 2'b11});
      wr(ADDR_CTRL_MAIN, 8'hE0);
      wr(ADDR_TMR_HI, 8'($urandom));
      wr(ADDR_TMR_LO, 8'hFE);
      fire(3'h0, 1'b0, 1'b0, 2);
      take(p[0], ADDR_CTRL_MAIN, 8'hE0);
      wr(ADDR_CTRL_THREE, {1'b0, p[0], 6'b001000});
      pins[1] <= 1'b1;
      take(p[0], ADDR_CTRL_THREE, {1'b0, p[0], 6'b001000});
      pins[1] <= 1'b0;
    end
    wr(ADDR_TMR_CFG, 8'h01);
    wr(ADDR_TMR_LO, 8'hFF);
    wr(ADDR_TMR_HI, 8'hFE);
    fire(3'h0, 1'b0, 1'b0, 1);
    rd(ADDR_CTRL_MAIN, 8'hE0);
    wr(ADDR_TMR_HI, 8'hFF);
    wr(ADDR_TMR_LO, 8'hFF);
    fire(3'h0, 1'b0, 1'b0, 1);
    take(1'b1, ADDR_CTRL_MAIN, 8'hE0);
    wr(ADDR_CTRL_MAIN, 8'hC0);
    wr(ADDR_TMR_CFG, 8'h00);
    wr(ADDR_TMR_LO, 8'hFF);
    fire(3'h0, 1'b0, 1'b0, 1);
    rd(ADDR_CTRL_MAIN, 8'hC4);
    @(negedge mclk_i);
    chk(vreq, 1'b0, "timer vector while disabled");
    wr(ADDR_CTRL_TWO, 8'hFE);
    wr(ADDR_CTRL_MAIN, 8'hC8);
    pb <= 4'($urandom_range(1, 15));
    take(1'b0, ADDR_CTRL_MAIN, 8'hC8);
    wr(ADDR_CTRL_MAIN, 8'hD0);
    pins[0] <= 1'b1;
    take(1'b1, ADDR_CTRL_MAIN, 8'hD0);
    wr(ADDR_PERIPH_PRI6, 8'h16);
    wr(ADDR_PERIPH_EN, 8'h11);
    fire(3'h1, 1'b0, 1'b0, 0);
    take(1'b0, ADDR_PERIPH_FLAG, 8'h00);
    fire(3'h0, 1'b1, 1'b0, 0);
    take(1'b1, ADDR_PERIPH_FLAG, 8'h00);
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule
bind ipc_irq_ctrl ipc_irq_ctrl_checker #(.PC_W(PC_W)) ipc_irq_ctrl_checker_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .sleeping_i(sleeping_i), .ack_i(ack_i), .pc_i(pc_i), .ctx_i(ctx_i), .wake_o(wake_o),
  .vector_req_o(vector_req_o), .vector_high_o(vector_high_o), .push_o(push_o),
  .push_pc_o(push_pc_o), .fast_ctx_o(fast_ctx_o));
